// [core/utq_buffers.sv]
// outgoing message queues and incoming circular store
// How it works
// [R01] queue location 0 length, data alternate D3h/C2h
// [R02] outgoing clear zeroes selectors, restores queue defaults
// [R03] length above 86 stored as 56h
// [R04] unlimited option allows lengths up to 255
// [R05] past stored data, send alternating fill bytes
// [R06] wrong length caught by lockstep monitor outside
// [R07] host composes 3 to 31 byte messages
// [R08] writes beyond location 31 are discarded
// [R09] load queue never sent; advance makes eligible
// [R10] both two-bit selectors wrap 3 to 0
// [R11] full when load equals transmit minus one
// [R12] empty when no loaded queue waits
// [R13] send only when mode, data, space, lockstep allow
// [R14] queued message beats fault report packet
// [R15] after sending, restore queue and release it
// [R16] 86-byte ring written by receiver, read by host
// [R17] read 00h, write 01h, next-message 00h pointers
// [R18] empty when read is write minus one, reads zero
// [R19] incoming clear resets pointers, zeroes all bytes
// [R20] incoming clear resets receiver; resync needed
// [R21] host avoids clearing during continuous preambles
// [R22] system supplies a separate resync preamble or idle
// [R23] four fixed queues, two-bit load/transmit selectors
`timescale 1ns/100ps
`default_nettype none
`include "utq_defs.svh"
module utq_buffers #(
    parameter int RING_DEPTH = 86,
    parameter logic [15:0] RESYNC_BITS = `UTQ_RESYNC_BITS
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // configuration
    input wire logic queue_mode_en,
    input wire logic unlimited_en,
    input wire logic lockstep_store_full,
    // host commands
    input wire logic clear_outgoing_store_cmd,
    input wire logic clear_incoming_store_cmd,
    input wire logic advance_load_cmd,
    input wire logic load_wr_en,
    input wire utq_pkg::utq_load_t load_wr,
    // outgoing status
    output logic [1:0] load_queue_select,
    output logic [1:0] transmit_queue_select,
    output logic outgoing_full,
    output logic outgoing_empty,
    output logic outgoing_overflow,
    output logic fault_report_grant,
    input wire logic fault_report_req,
    // outgoing byte stream to the serialiser
    output logic tx_valid,
    input wire logic tx_ready,
    output utq_pkg::utq_byte_t tx_byte,
    // receiver side (line-facing, resync uses serial bit strobe)
    input wire logic rx_bit_tick,
    input wire logic rx_line_idle,
    input wire logic rx_preamble_seen,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_synced,
    output logic incoming_overflow,
    // host reading
    input wire logic host_rd_req,
    input wire logic next_msg_mark,
    output logic [7:0] host_rd_data,
    output logic host_rd_valid,
    output logic incoming_empty,
    output logic [6:0] incoming_read_pointer,
    output logic [6:0] incoming_write_pointer,
    output logic [6:0] next_unread_pointer,
    output logic [6:0] rx_space
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] fill_of(input logic [4:0] loc);
        return loc[0] ? `UTQ_FILL_ODD : `UTQ_FILL_EVEN; // [R01]
    endfunction
    function automatic logic [6:0] ring_inc(input logic [6:0] p);
        return (p == `UTQ_RING_LAST) ? 7'h00 : p + 7'h01;
    endfunction

    // ----------------------------------------
    // outgoing queues
    // ----------------------------------------
    // written flags let a clear restore 128 bytes in one cycle
    logic [7:0] qdata [4][32]; // [R23]
    logic [31:0] qwritten [4];
    logic [7:0] qlen [4];
    logic overflow_flag;
    utq_pkg::utq_tx_state_t state;
    logic [7:0] sent_count;

    wire logic [1:0] load_plus = load_queue_select + 2'h1; // [R10]
    wire logic [1:0] tx_minus = transmit_queue_select - 2'h1;
    wire logic is_full = (load_queue_select == tx_minus); // [R11]
    wire logic is_empty = (load_queue_select == transmit_queue_select); // [R12]
    wire logic [7:0] len_clamped = unlimited_en ? load_wr.data :
        ((load_wr.data > `UTQ_LEN_LIMIT) ? `UTQ_LEN_LIMIT : load_wr.data); // [R03] [R04]
    wire logic write_len = load_wr_en && (load_wr.loc == `UTQ_LEN_LOC);
    wire logic write_data = load_wr_en && (load_wr.loc != `UTQ_LEN_LOC); // [R08]
    // stored length goes out unchanged, so the lockstep monitor sees any mismatch
    wire logic [7:0] cur_len = qlen[transmit_queue_select]; // [R06]
    wire logic space_ok = unlimited_en || ({1'b0, rx_space} >= cur_len); // [R13]
    wire logic start_ok = queue_mode_en && !is_empty && space_ok
        && !lockstep_store_full && (state == utq_pkg::UTQ_IDLE); // [R13] [R09]
    wire logic [7:0] next_pos = sent_count + 8'h01;
    wire logic [4:0] send_loc = next_pos[4:0];
    wire logic in_queue = (next_pos <= {3'h0, `UTQ_LAST_LOC});
    wire logic [7:0] send_byte = (in_queue && qwritten[transmit_queue_select][send_loc])
        ? qdata[transmit_queue_select][send_loc] : fill_of(send_loc); // [R05]
    wire logic buf_in_ready;
    wire logic push = (state == utq_pkg::UTQ_SEND) && buf_in_ready;
    wire logic last_byte = (next_pos == cur_len);

    assign outgoing_full = is_full;
    assign outgoing_empty = is_empty;
    assign outgoing_overflow = overflow_flag;
    assign fault_report_grant = fault_report_req && !start_ok
        && (state == utq_pkg::UTQ_IDLE); // [R14]

    always_ff @(posedge clk) begin
        if (!reset_n || clear_outgoing_store_cmd) begin
            load_queue_select <= `UTQ_SEL_RESET; // [R02]
            transmit_queue_select <= `UTQ_SEL_RESET;
            overflow_flag <= 1'b0;
            state <= utq_pkg::UTQ_IDLE;
            sent_count <= 8'h00;
            for (int q = 0; q < 4; q++) begin
                qwritten[q] <= 32'h0;
                qlen[q] <= `UTQ_LEN_DEFAULT;
            end
        end else begin
            if (advance_load_cmd) begin
                if (is_full) begin
                    overflow_flag <= 1'b1; // [R11]
                end else begin
                    load_queue_select <= load_plus; // [R09]
                end
            end
            if (write_len) begin
                qlen[load_wr.queue] <= len_clamped;
            end
            if (write_data) begin
                qdata[load_wr.queue][load_wr.loc] <= load_wr.data;
                qwritten[load_wr.queue][load_wr.loc] <= 1'b1;
            end
            case (state)
                utq_pkg::UTQ_IDLE: begin
                    sent_count <= 8'h00;
                    if (start_ok) begin
                        state <= (cur_len == 8'h00) ? utq_pkg::UTQ_SCRUB
                            : utq_pkg::UTQ_SEND;
                    end
                end
                utq_pkg::UTQ_SEND: begin
                    if (push) begin
                        sent_count <= next_pos;
                        if (last_byte) begin
                            state <= utq_pkg::UTQ_SCRUB;
                        end
                    end
                end
                utq_pkg::UTQ_SCRUB: begin
                    qwritten[transmit_queue_select] <= 32'h0; // [R15]
                    qlen[transmit_queue_select] <= `UTQ_LEN_DEFAULT;
                    transmit_queue_select <= transmit_queue_select + 2'h1; // [R10]
                    state <= utq_pkg::UTQ_IDLE;
                end
                default: begin
                    state <= utq_pkg::UTQ_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // two-entry skid buffer toward serialiser
    // ----------------------------------------
    utq_pkg::utq_byte_t skid [2];
    logic [1:0] skid_count;
    logic skid_rd;
    wire logic pop = tx_valid && tx_ready;
    assign buf_in_ready = (skid_count != 2'h2);
    assign tx_valid = (skid_count != 2'h0);
    assign tx_byte = skid[skid_rd];
    wire logic skid_wr = skid_rd ^ skid_count[0];

    always_ff @(posedge clk) begin
        if (!reset_n || clear_outgoing_store_cmd) begin
            skid_count <= 2'h0;
            skid_rd <= 1'b0;
        end else begin
            if (push) begin
                skid[skid_wr] <= '{data: send_byte, last: last_byte};
            end
            if (pop) begin
                skid_rd <= ~skid_rd;
            end
            skid_count <= skid_count + {1'b0, push} - {1'b0, pop};
        end
    end

    // ----------------------------------------
    // incoming ring store
    // ----------------------------------------
    logic [6:0] rd_ptr;
    logic [6:0] wr_ptr;
    logic [6:0] nxt_ptr;
    logic ovf;
    logic clearing;
    logic [6:0] clear_addr;
    logic rd_pending;
    logic rd_hit;
    logic [15:0] idle_bits;
    logic [7:0] mem_q;

    wire logic [6:0] wr_after = ring_inc(wr_ptr);
    wire logic is_rx_empty = (ring_inc(rd_ptr) == wr_ptr); // [R18]
    wire logic ring_full = (wr_after == rd_ptr);
    wire logic store = rx_valid && rx_synced && !clearing; // [R16]
    wire logic take = host_rd_req && !is_rx_empty && !clearing;
    wire logic mem_we = clearing || store;
    wire logic [6:0] mem_wa = clearing ? clear_addr : wr_ptr;
    wire logic [7:0] mem_wd = clearing ? 8'h00 : rx_data; // [R19]
    wire logic [6:0] mem_ra = ring_inc(rd_ptr);
    wire logic [6:0] used = (wr_ptr >= rd_ptr) ? (wr_ptr - rd_ptr)
        : (wr_ptr + `UTQ_RING_SIZE - rd_ptr);

    assign incoming_empty = is_rx_empty;
    assign incoming_read_pointer = rd_ptr;
    assign incoming_write_pointer = wr_ptr;
    assign next_unread_pointer = nxt_ptr;
    assign incoming_overflow = ovf;
    assign rx_space = `UTQ_RING_SIZE - used;

    utq_ring_mem #(.DEPTH(RING_DEPTH), .AW(7)) u_ring (
        .clk(clk),
        .wr_en(mem_we),
        .wr_addr(mem_wa),
        .wr_data(mem_wd),
        .rd_addr(mem_ra),
        .rd_data(mem_q)
    );

    always_ff @(posedge clk) begin
        if (!reset_n || clear_incoming_store_cmd) begin
            rd_ptr <= `UTQ_RD_PTR_RESET; // [R17] [R19]
            wr_ptr <= `UTQ_WR_PTR_RESET;
            nxt_ptr <= `UTQ_NXT_PTR_RESET;
            ovf <= 1'b0;
            clearing <= 1'b1;
            clear_addr <= 7'h00;
            rd_pending <= 1'b0;
            rd_hit <= 1'b0;
            host_rd_valid <= 1'b0;
            host_rd_data <= 8'h00;
        end else begin
            if (clearing) begin
                clear_addr <= clear_addr + 7'h01;
                if (clear_addr == `UTQ_RING_LAST) begin
                    clearing <= 1'b0;
                end
            end
            // at the last free slot the receiver overwrites in place
            // a read in the same cycle frees a slot, so that is no overflow
            if (store) begin
                if (ring_full && !take) begin
                    ovf <= 1'b1;
                end else begin
                    wr_ptr <= wr_after;
                end
            end
            if (take) begin
                rd_ptr <= ring_inc(rd_ptr);
                ovf <= 1'b0;
            end
            if (next_msg_mark) begin
                nxt_ptr <= wr_ptr;
            end
            rd_pending <= host_rd_req;
            rd_hit <= take;
            host_rd_valid <= rd_pending;
            // emptiness judged when the read is taken, not after the pointer moved
            host_rd_data <= rd_hit ? mem_q : 8'h00; // [R18]
        end
    end

    // ----------------------------------------
    // receiver resynchronisation after clear
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n || clear_incoming_store_cmd) begin
            rx_synced <= 1'b0; // [R20]
            idle_bits <= 16'h0000;
        end else if (!rx_synced) begin
            if (rx_preamble_seen) begin
                rx_synced <= 1'b1;
            end else if (!rx_line_idle) begin
                idle_bits <= 16'h0000;
            end else if (rx_bit_tick) begin
                idle_bits <= idle_bits + 16'h0001;
                if (idle_bits + 16'h0001 >= RESYNC_BITS) begin
                    rx_synced <= 1'b1; // [R20] [R22]
                end
            end
        end
    end
endmodule
`default_nettype wire

// [inc/utq_defs.svh]
// constants for the outgoing queues and incoming ring store
`ifndef UTQ_DEFS_SVH
`define UTQ_DEFS_SVH
`define UTQ_QUEUE_COUNT 4
`define UTQ_QUEUE_DEPTH 32
`define UTQ_LAST_LOC 5'h1F
`define UTQ_LEN_LOC 5'h00
`define UTQ_LEN_DEFAULT 8'h00
`define UTQ_FILL_ODD 8'hD3
`define UTQ_FILL_EVEN 8'hC2
`define UTQ_LEN_LIMIT 8'h56
`define UTQ_LEN_UNLIMITED 8'hFF
`define UTQ_SEL_RESET 2'h0
`define UTQ_RING_SIZE 7'h56
`define UTQ_RING_LAST 7'h55
`define UTQ_RD_PTR_RESET 7'h00
`define UTQ_WR_PTR_RESET 7'h01
`define UTQ_NXT_PTR_RESET 7'h00
`define UTQ_RESYNC_BITS 16'h000A
`endif

// [inc/utq_pkg.sv]
// shared types for the outgoing queues and incoming ring store
package utq_pkg;
    typedef struct packed {
        logic [1:0] queue;
        logic [4:0] loc;
        logic [7:0] data;
    } utq_load_t;
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } utq_byte_t;
    typedef enum logic [1:0] {UTQ_IDLE, UTQ_SEND, UTQ_SCRUB} utq_tx_state_t;
endpackage

// [core/utq_ring_mem.sv]
// incoming ring store memory, registered read, bulk clear by walking
`timescale 1ns/100ps
`default_nettype none
module utq_ring_mem #(
    parameter int DEPTH = 86,
    parameter int AW = 7
) (
    // clock
    input wire logic clk,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // read port
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// [test/utq_sink.sv]
// serialiser-side sink that takes the outgoing byte stream
`timescale 1ns/100ps
`default_nettype none
module utq_sink (
    // clock
    input wire logic clk,
    // byte stream from the block
    input wire logic tx_valid,
    input wire utq_pkg::utq_byte_t tx_byte,
    output logic tx_ready,
    // bench control and capture
    input wire logic stall,
    input wire logic clr,
    output logic [7:0] got [0:255],
    output int got_n,
    output int last_n
);
    // ready follows stall one edge late, so the block sees stalls mid-message
    always @(posedge clk) begin
        tx_ready <= !stall;
        if (clr) begin
            got_n <= 0;
            last_n <= -1;
        end else if (tx_valid && tx_ready) begin
            got[got_n[7:0]] <= tx_byte.data;
            got_n <= got_n + 1;
            if (tx_byte.last) begin
                last_n <= got_n;
            end
        end
    end
endmodule
`default_nettype wire

// [test/utq_buffers_chk.sv]
// port-level assertions for the queue and ring block
`timescale 1ns/100ps
`default_nettype none
module utq_buffers_chk (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // commands
    input wire logic clear_outgoing_store_cmd,
    input wire logic clear_incoming_store_cmd,
    input wire logic advance_load_cmd,
    input wire logic host_rd_req,
    // status
    input wire logic [1:0] load_queue_select,
    input wire logic [1:0] transmit_queue_select,
    input wire logic outgoing_full,
    input wire logic outgoing_empty,
    input wire logic outgoing_overflow,
    input wire logic [7:0] host_rd_data,
    input wire logic host_rd_valid,
    input wire logic incoming_empty,
    input wire logic [6:0] incoming_read_pointer,
    input wire logic [6:0] incoming_write_pointer,
    input wire logic [6:0] next_unread_pointer,
    input wire logic rx_synced
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ----
    // named steps
    // ----
    sequence s_adv_full;
        advance_load_cmd && outgoing_full && !clear_outgoing_store_cmd;
    endsequence
    sequence s_adv_free;
        advance_load_cmd && !outgoing_full && !clear_outgoing_store_cmd;
    endsequence
    sequence s_empty_read;
        host_rd_req && incoming_empty && !clear_incoming_store_cmd;
    endsequence
    a_full_flag: assert property (
        outgoing_full == (load_queue_select == transmit_queue_select - 2'h1))
        else $error("full flag wrong");
    a_empty_flag: assert property (
        load_queue_select == transmit_queue_select |-> outgoing_empty)
        else $error("empty flag wrong");
    a_full_refuse: assert property (
        s_adv_full |=> outgoing_overflow && $stable(load_queue_select))
        else $error("advance while full not refused");
    a_load_advance: assert property (
        s_adv_free |=> load_queue_select == $past(load_queue_select) + 2'h1)
        else $error("load select did not step");
    a_out_clear: assert property (
        clear_outgoing_store_cmd |=> load_queue_select == 2'h0
            && transmit_queue_select == 2'h0 && !outgoing_overflow)
        else $error("outgoing clear incomplete");
    a_empty_read: assert property (
        s_empty_read |-> ##2 host_rd_valid && host_rd_data == 8'h00)
        else $error("empty read not zero");
    a_in_clear: assert property (
        clear_incoming_store_cmd |=> incoming_read_pointer == 7'h00
            && incoming_write_pointer == 7'h01 && next_unread_pointer == 7'h00 && !rx_synced)
        else $error("incoming clear incomplete");
    a_ring_empty: assert property (incoming_empty == (incoming_read_pointer ==
        ((incoming_write_pointer == 7'h00) ? 7'h55 : incoming_write_pointer - 7'h01)))
        else $error("ring empty flag wrong");
endmodule
bind utq_buffers utq_buffers_chk u_chk (.clk, .reset_n, .clear_outgoing_store_cmd,
    .clear_incoming_store_cmd, .advance_load_cmd, .host_rd_req, .load_queue_select,
    .transmit_queue_select, .outgoing_full, .outgoing_empty, .outgoing_overflow,
    .host_rd_data, .host_rd_valid, .incoming_empty, .incoming_read_pointer,
    .incoming_write_pointer, .next_unread_pointer, .rx_synced);
`default_nettype wire

// [test/utq_buffers_tb.sv]
// self-checking bench for the queue and ring block
`timescale 1ns/100ps
`default_nettype none
module utq_buffers_tb;
    logic clk = 1'b0;
    logic reset_n, queue_mode_en, unlimited_en, lockstep_store_full, load_wr_en, stall;
    logic clear_outgoing_store_cmd, clear_incoming_store_cmd, advance_load_cmd, sk_clr;
    logic fault_report_req, fault_report_grant, tx_valid, tx_ready, rx_synced;
    logic rx_bit_tick, rx_line_idle, rx_valid, host_rd_req, host_rd_valid;
    logic outgoing_full, outgoing_empty, outgoing_overflow, incoming_empty, incoming_overflow;
    logic rx_preamble_seen, next_msg_mark;
    logic [7:0] rx_data, host_rd_data;
    logic [7:0] sk_got [0:255];
    logic [1:0] load_queue_select, transmit_queue_select;
    logic [6:0] incoming_read_pointer, incoming_write_pointer, next_unread_pointer;
    utq_pkg::utq_load_t load_wr;
    utq_pkg::utq_byte_t tx_byte;
    int sk_n, sk_last, err_total, total_checks;
    always #12.5 clk = ~clk;
    utq_buffers uut (.clk, .reset_n, .queue_mode_en, .unlimited_en, .lockstep_store_full,
        .clear_outgoing_store_cmd, .clear_incoming_store_cmd, .advance_load_cmd, .load_wr_en,
        .load_wr, .load_queue_select, .transmit_queue_select, .outgoing_full, .outgoing_empty,
        .outgoing_overflow, .fault_report_grant, .fault_report_req, .tx_valid, .tx_ready,
        .tx_byte, .rx_bit_tick, .rx_line_idle, .rx_preamble_seen, .rx_valid, .rx_data,
        .rx_synced, .incoming_overflow, .host_rd_req, .next_msg_mark, .host_rd_data,
        .host_rd_valid, .incoming_empty, .incoming_read_pointer, .incoming_write_pointer,
        .next_unread_pointer, .rx_space());
    utq_sink sink (.clk, .tx_valid, .tx_byte, .tx_ready, .stall, .clr(sk_clr), .got(sk_got),
        .got_n(sk_n), .last_n(sk_last));
    // ----
    // access tasks
    // ----
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR at %0t: saw %h expected %h", $time, g, e);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // length at location 0, one data byte, rest left at defaults
    task automatic load(input logic [1:0] q, input logic [7:0] len);
        load_wr_en = 1'b1;
        load_wr = {q, 5'h00, len};
        tick(1);
        load_wr = {q, 5'h01, 8'h57};
        tick(1);
        load_wr_en = 1'b0;
        advance_load_cmd = 1'b1;
        tick(1);
        advance_load_cmd = 1'b0;
    endtask
    task automatic collect(input logic [1:0] q, input int n);
        int k;
        k = 0;
        while (sk_last < 0 && k < 3000) begin
            stall = k[2];
            tick(1);
            k++;
        end
        stall = 1'b0;
        tick(4);
        chk(sk_n, n);
        chk(sk_last, n - 1);
        chk(sk_got[0], 8'h57);
        for (k = 1; k < n; k++) begin
            chk(sk_got[k], k[0] ? 8'hC2 : 8'hD3);
        end
        chk(transmit_queue_select, 2'(q + 2'h1));
        sk_clr = 1'b1;
        tick(1);
        sk_clr = 1'b0;
        $display("message of %0d bytes done", n);
    endtask
    task automatic rd(input logic [7:0] e);
        int k;
        k = 0;
        host_rd_req = 1'b1;
        tick(1);
        host_rd_req = 1'b0;
        while (host_rd_valid !== 1'b1 && k < 4) begin
            tick(1);
            k++;
        end
        chk({host_rd_valid, host_rd_data}, {1'b1, e});
    endtask
    // ----
    // tests
    // ----
    initial begin
        {reset_n, unlimited_en, lockstep_store_full, load_wr_en, stall, host_rd_req} = '0;
        {clear_outgoing_store_cmd, clear_incoming_store_cmd, advance_load_cmd} = '0;
        {fault_report_req, rx_bit_tick, rx_line_idle, rx_valid, rx_data} = '0;
        {rx_preamble_seen, next_msg_mark} = '0;
        {queue_mode_en, sk_clr, load_wr} = {2'h3, 15'h0000};
        tick(16);
        reset_n = 1'b1;
        sk_clr = 1'b0;
        tick(1);
        chk({incoming_read_pointer, incoming_write_pointer}, 14'h0001);
        chk({next_unread_pointer, load_queue_select, transmit_queue_select}, 11'h000);
        chk({outgoing_empty, outgoing_full, incoming_empty}, 3'h5);
        $display("reset defaults done");
        fault_report_req = 1'b1;
        tick(90);
        chk(fault_report_grant, 1'b1);
        lockstep_store_full = 1'b1;
        load(2'h0, 8'h03);
        tick(20);
        chk({tx_valid, outgoing_empty}, 2'h0);
        lockstep_store_full = 1'b0;
        #1;
        chk(fault_report_grant, 1'b0);
        collect(2'h0, 3);
        load(2'h1, 8'h23);
        collect(2'h1, 35);
        load(2'h2, 8'hC8);
        unlimited_en = 1'b1;
        collect(2'h2, 86);
        load(2'h3, 8'hFF);
        collect(2'h3, 255);
        chk(load_queue_select, 2'h0);
        {unlimited_en, fault_report_req, queue_mode_en} = '0;
        repeat (4) begin
            advance_load_cmd = 1'b1;
            tick(1);
            advance_load_cmd = 1'b0;
            tick(1);
        end
        chk({load_queue_select, outgoing_full, outgoing_overflow}, 4'hF);
        clear_outgoing_store_cmd = 1'b1;
        tick(1);
        clear_outgoing_store_cmd = 1'b0;
        chk({load_queue_select, transmit_queue_select, outgoing_overflow}, 5'h00);
        $display("full and clear done");
        {rx_line_idle, rx_bit_tick, rx_data} = {2'h3, 8'h3C};
        tick(12);
        rx_bit_tick = 1'b0;
        chk(rx_synced, 1'b1);
        rx_valid = 1'b1;
        tick(1);
        rx_valid = 1'b0;
        chk({incoming_overflow, incoming_empty, incoming_write_pointer}, 9'h002);
        rd(8'h3C);
        rd(8'h00);
        rx_valid = 1'b1;
        tick(1);
        rx_valid = 1'b0;
        next_msg_mark = 1'b1;
        tick(1);
        next_msg_mark = 1'b0;
        chk(next_unread_pointer, 7'h03);
        rx_valid = 1'b1;
        tick(90);
        rx_valid = 1'b0;
        chk({incoming_overflow, incoming_write_pointer}, 8'h80);
        clear_incoming_store_cmd = 1'b1;
        tick(1);
        clear_incoming_store_cmd = 1'b0;
        chk({incoming_read_pointer, incoming_write_pointer, next_unread_pointer}, 21'h000080);
        chk({incoming_overflow, rx_synced}, 2'h0);
        tick(90);
        rd(8'h00);
        rx_valid = 1'b1;
        tick(1);
        rx_valid = 1'b0;
        chk({rx_synced, incoming_write_pointer}, 8'h01);
        rx_preamble_seen = 1'b1;
        tick(1);
        rx_preamble_seen = 1'b0;
        chk(rx_synced, 1'b1);
        $display("incoming store done");
        summarize();
    end
    // about thirty microseconds of tests, so this only fires on a hang
    initial begin
        #200us;
        err_total++;
        summarize();
    end
endmodule
`default_nettype wire
